// ===== rtl/gpio_latch_regs.vh
`ifndef GPIO_LATCH_REGS_VH
`define GPIO_LATCH_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_PORT_A_PIN_DATA 8'h00
`define OFS_PORT_B_PIN_DATA 8'h04
`define OFS_PORT_A_LATCH_SET 8'h08
`define OFS_PORT_A_LATCH_CLEAR 8'h0c
`define OFS_PORT_A_LATCH_TOGGLE 8'h10
`define OFS_PORT_B_LATCH_SET 8'h14
`define OFS_PORT_B_LATCH_CLEAR 8'h18
`define OFS_PORT_B_LATCH_TOGGLE 8'h1c
`define OFS_PORT_A_FUNC_SEL 8'h20
`define OFS_PORT_A_DIRECTION 8'h24
`define OFS_PORT_B_FUNC_SEL 8'h28
`define OFS_PORT_B_DIRECTION 8'h2c
`define OFS_PORT_A_LATCH_VIEW 8'h30
`define OFS_PORT_B_LATCH_VIEW 8'h34

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define BUS_ADR_W 8
`define BUS_DAT_W 32
`define PORT_A_PINS 32
`define PORT_B_PINS 3
`define PORT_B_FIELD_MSB 2
`define PORT_B_FIELD_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_LATCH 32'h00000000
`define RST_FUNC_SEL 32'h00000000
`define RST_DIRECTION 32'h00000000
`define RST_RDATA 32'h00000000

`endif

// ===== rtl/gpio_wb_slave.v
`timescale 1ns/1ps
`include "gpio_latch_regs.vh"

// ----------------------------------------------------------------
// Classic Wishbone slave front end, one wait state
// ----------------------------------------------------------------
module gpio_wb_slave (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave side
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire [`BUS_DAT_W-1:0] dat_i,
  output wire ack_o,
  // Decoded request towards the register file
  output wire accept_o,
  output wire write_o,
  output wire [`BUS_DAT_W-1:0] lane_mask_o,
  output wire [`BUS_DAT_W-1:0] wdata_o
);

  reg ack_r;

  // Ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
    end
  end

  assign ack_o = ack_r;
  // Read data is captured on acceptance so it stands with ack
  assign accept_o = cyc_i & stb_i & ~ack_r;
  // Writes act on the edge where the master sees ack
  assign write_o = cyc_i & stb_i & we_i & ack_r;
  // Unselected byte lanes carry no ones into the block
  assign lane_mask_o = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wdata_o = dat_i & lane_mask_o;

endmodule // gpio_wb_slave

// ===== rtl/gpio_latch_port.v
`timescale 1ns/1ps
`include "gpio_latch_regs.vh"

// ----------------------------------------------------------------
// Output data latches and pin drive for one port
// ----------------------------------------------------------------
module gpio_latch_port #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // One-cycle bit masks from the register file
  input wire [WIDTH-1:0] set_i,
  input wire [WIDTH-1:0] clr_i,
  input wire [WIDTH-1:0] tgl_i,
  input wire [WIDTH-1:0] dat_we_i,
  input wire [WIDTH-1:0] dat_wd_i,
  // Pin configuration
  input wire [WIDTH-1:0] func_sel_i,
  input wire [WIDTH-1:0] dir_i,
  // Pins
  input wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] pin_o,
  output wire [WIDTH-1:0] pin_oe_o,
  // State views
  output wire [WIDTH-1:0] latch_o,
  output wire [WIDTH-1:0] pin_level_o
);

  reg [WIDTH-1:0] latch_r;
  reg [WIDTH-1:0] pin_level_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Each bit acts alone; zero bits leave it as it is
      always @(posedge clk_i) begin
        if (rst_i) begin
          latch_r[i] <= 1'b0; // [R12]
        end else if (set_i[i]) begin
          latch_r[i] <= 1'b1; // [R1] [R15]
        end else if (clr_i[i]) begin
          latch_r[i] <= 1'b0; // [R2] [R15]
        end else if (tgl_i[i]) begin
          latch_r[i] <= ~latch_r[i]; // [R3] [R15]
        end else if (dat_we_i[i]) begin
          latch_r[i] <= dat_wd_i[i]; // [R12]
        end
      end

      // Drive only when muxed to GPIO and set as output
      assign pin_oe_o[i] = ~func_sel_i[i] & dir_i[i]; // [R14] [R9]
    end
  endgenerate

  // Pin level sampled once; the block keeps no other filter
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_level_r <= {WIDTH{1'b0}};
    end else begin
      pin_level_r <= pin_i; // [R13]
    end
  end

  assign pin_o = latch_r; // [R6] [R7] [R8]
  assign latch_o = latch_r;
  assign pin_level_o = pin_level_r;

endmodule // gpio_latch_port

// ===== rtl/gpio_latch_set_clear_toggle.v
// Notes on behaviour
// (R1) A one written to a set register drives that output latch high.
// (R2) A one written to a clear register drives that output latch low.
// (R3) A one written to a toggle register inverts that output latch.
// (R4) Zero bits in set, clear or toggle writes change nothing.
// (R5) Set, clear and toggle registers always read back as zero.
// (R6) On a GPIO output pin, set drives the pin high.
// (R7) On a GPIO output pin, clear drives the pin low.
// (R8) On a GPIO output pin, toggle drives the pin to the opposite level.
// (R9) On other pins only the latch changes; the pin stays undriven.
// (R10) Port A registers are 32 bits, bit n for pin n.
// (R11) Port B registers use bits 2..0 for pins 32..34; upper bits read zero.
// (R12) Latches are shared with the data register path; reset clears them.
// (R13) Reading a data register returns the sampled pin level, not the latch.
// (R14) A pin is a GPIO output only if function select and direction agree.
// (R15) Bits of one write act independently; zero bits keep their latches.
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "gpio_latch_regs.vh"

module gpio_latch_set_clear_toggle #(
  parameter PA_W = `PORT_A_PINS,
  parameter PB_W = `PORT_B_PINS
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [`BUS_ADR_W-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [`BUS_DAT_W-1:0] dat_i,
  output wire [`BUS_DAT_W-1:0] dat_o,
  output wire ack_o,
  // Port A pins
  input wire [PA_W-1:0] pin_a_i,
  output wire [PA_W-1:0] pin_a_o,
  output wire [PA_W-1:0] pin_a_oe_o,
  // Port B pins
  input wire [PB_W-1:0] pin_b_i,
  output wire [PB_W-1:0] pin_b_o,
  output wire [PB_W-1:0] pin_b_oe_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wire accept;
  wire write;
  wire [`BUS_DAT_W-1:0] lane_mask;
  wire [`BUS_DAT_W-1:0] wdata;
  wire [`BUS_ADR_W-1:0] word_adr;
  wire [PA_W-1:0] lane_a;
  wire [PA_W-1:0] wdata_a;
  wire [PB_W-1:0] lane_b;
  wire [PB_W-1:0] wdata_b;

  wire hit_a_dat;
  wire hit_b_dat;
  wire hit_a_set;
  wire hit_a_clr;
  wire hit_a_tgl;
  wire hit_b_set;
  wire hit_b_clr;
  wire hit_b_tgl;
  wire hit_a_fsel;
  wire hit_a_dir;
  wire hit_b_fsel;
  wire hit_b_dir;

  wire [PA_W-1:0] a_set;
  wire [PA_W-1:0] a_clr;
  wire [PA_W-1:0] a_tgl;
  wire [PA_W-1:0] a_dat_we;
  wire [PB_W-1:0] b_set;
  wire [PB_W-1:0] b_clr;
  wire [PB_W-1:0] b_tgl;
  wire [PB_W-1:0] b_dat_we;

  wire [PA_W-1:0] a_latch;
  wire [PA_W-1:0] a_level;
  wire [PB_W-1:0] b_latch;
  wire [PB_W-1:0] b_level;

  reg [PA_W-1:0] a_fsel_r;
  reg [PA_W-1:0] a_fsel_nxt;
  reg [PA_W-1:0] a_dir_r;
  reg [PA_W-1:0] a_dir_nxt;
  reg [PB_W-1:0] b_fsel_r;
  reg [PB_W-1:0] b_fsel_nxt;
  reg [PB_W-1:0] b_dir_r;
  reg [PB_W-1:0] b_dir_nxt;

  reg [`BUS_DAT_W-1:0] rdata_r;
  reg [`BUS_DAT_W-1:0] rdata_nxt;

  // Reset constants, cut to each register's width below
  localparam [`BUS_DAT_W-1:0] RST_FSEL_WORD = `RST_FUNC_SEL;
  localparam [`BUS_DAT_W-1:0] RST_DIR_WORD = `RST_DIRECTION;

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  gpio_wb_slave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .ack_o(ack_o),
    .accept_o(accept),
    .write_o(write),
    .lane_mask_o(lane_mask),
    .wdata_o(wdata)
  );

  // ----------------------------------------------------------------
  // Per-port views of the write word
  // ----------------------------------------------------------------
  // Port B keeps bits 2..0 only; reserved bits never reach it
  assign lane_a = lane_mask[PA_W-1:0];
  assign wdata_a = wdata[PA_W-1:0];
  assign lane_b = lane_mask[PB_W-1:0];
  assign wdata_b = wdata[PB_W-1:0];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Low address bits ignored: every register is one aligned word
  assign word_adr = {adr_i[`BUS_ADR_W-1:2], 2'b00};

  // Data words: written into the latches, read as pin levels
  assign hit_a_dat = (word_adr == `OFS_PORT_A_PIN_DATA);
  assign hit_b_dat = (word_adr == `OFS_PORT_B_PIN_DATA);

  // Write-only set, clear and toggle words
  assign hit_a_set = (word_adr == `OFS_PORT_A_LATCH_SET);
  assign hit_a_clr = (word_adr == `OFS_PORT_A_LATCH_CLEAR);
  assign hit_a_tgl = (word_adr == `OFS_PORT_A_LATCH_TOGGLE);
  assign hit_b_set = (word_adr == `OFS_PORT_B_LATCH_SET);
  assign hit_b_clr = (word_adr == `OFS_PORT_B_LATCH_CLEAR);
  assign hit_b_tgl = (word_adr == `OFS_PORT_B_LATCH_TOGGLE);

  // Pin configuration words
  assign hit_a_fsel = (word_adr == `OFS_PORT_A_FUNC_SEL);
  assign hit_a_dir = (word_adr == `OFS_PORT_A_DIRECTION);
  assign hit_b_fsel = (word_adr == `OFS_PORT_B_FUNC_SEL);
  assign hit_b_dir = (word_adr == `OFS_PORT_B_DIRECTION);

  // ----------------------------------------------------------------
  // Latch strobes
  // ----------------------------------------------------------------
  // Masks are the written ones only, so zero bits are inert;
  // lanes not selected were already forced to zero
  assign a_set = (write & hit_a_set) ? wdata[PA_W-1:0] : {PA_W{1'b0}}; // [R1] [R4] [R10]
  assign a_clr = (write & hit_a_clr) ? wdata[PA_W-1:0] : {PA_W{1'b0}}; // [R2] [R4] [R10]
  assign a_tgl = (write & hit_a_tgl) ? wdata[PA_W-1:0] : {PA_W{1'b0}}; // [R3] [R4] [R10]

  // Port B takes only the low field; bits 31..3 are dropped
  assign b_set = (write & hit_b_set) ? wdata[PB_W-1:0] : {PB_W{1'b0}}; // [R1] [R4] [R11]
  assign b_clr = (write & hit_b_clr) ? wdata[PB_W-1:0] : {PB_W{1'b0}}; // [R2] [R4] [R11]
  assign b_tgl = (write & hit_b_tgl) ? wdata[PB_W-1:0] : {PB_W{1'b0}}; // [R3] [R4] [R11]

  // Data register writes load the same latches, lane by lane
  assign a_dat_we = (write & hit_a_dat) ? lane_mask[PA_W-1:0] : {PA_W{1'b0}}; // [R12]
  assign b_dat_we = (write & hit_b_dat) ? lane_mask[PB_W-1:0] : {PB_W{1'b0}}; // [R12]

  // ----------------------------------------------------------------
  // Pin configuration registers
  // ----------------------------------------------------------------
  // Port A function select: byte-lane merge on a write
  always @* begin
    a_fsel_nxt = a_fsel_r;
    if (write & hit_a_fsel) begin
      a_fsel_nxt = (a_fsel_r & ~lane_a) | wdata_a;
    end
  end

  // Reset leaves every pin a GPIO input, so nothing drives
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_fsel_r <= RST_FSEL_WORD[PA_W-1:0];
    end else begin
      a_fsel_r <= a_fsel_nxt;
    end
  end

  // Port A direction: byte-lane merge on a write
  always @* begin
    a_dir_nxt = a_dir_r;
    if (write & hit_a_dir) begin
      a_dir_nxt = (a_dir_r & ~lane_a) | wdata_a;
    end
  end

  // Port A direction flops, inputs after reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_dir_r <= RST_DIR_WORD[PA_W-1:0];
    end else begin
      a_dir_r <= a_dir_nxt;
    end
  end

  // Port B function select: only the low field is kept
  always @* begin
    b_fsel_nxt = b_fsel_r;
    if (write & hit_b_fsel) begin
      b_fsel_nxt = (b_fsel_r & ~lane_b) | wdata_b;
    end
  end

  // Port B function select flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      b_fsel_r <= RST_FSEL_WORD[PB_W-1:0];
    end else begin
      b_fsel_r <= b_fsel_nxt;
    end
  end

  // Port B direction: byte-lane merge on a write
  always @* begin
    b_dir_nxt = b_dir_r;
    if (write & hit_b_dir) begin
      b_dir_nxt = (b_dir_r & ~lane_b) | wdata_b;
    end
  end

  // Port B direction flops, inputs after reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      b_dir_r <= RST_DIR_WORD[PB_W-1:0];
    end else begin
      b_dir_r <= b_dir_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Port latches and pin drive
  // ----------------------------------------------------------------
  // Port A: pins 0..31 on bits 0..31
  gpio_latch_port #(
    .WIDTH(PA_W)
  ) u_port_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(a_set),
    .clr_i(a_clr),
    .tgl_i(a_tgl),
    .dat_we_i(a_dat_we),
    .dat_wd_i(wdata[PA_W-1:0]),
    .func_sel_i(a_fsel_r),
    .dir_i(a_dir_r),
    .pin_i(pin_a_i),
    .pin_o(pin_a_o),
    .pin_oe_o(pin_a_oe_o),
    .latch_o(a_latch),
    .pin_level_o(a_level)
  );

  // Port B: pins 32..34 on bits 0..2
  gpio_latch_port #(
    .WIDTH(PB_W)
  ) u_port_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(b_set),
    .clr_i(b_clr),
    .tgl_i(b_tgl),
    .dat_we_i(b_dat_we),
    .dat_wd_i(wdata[PB_W-1:0]),
    .func_sel_i(b_fsel_r),
    .dir_i(b_dir_r),
    .pin_i(pin_b_i),
    .pin_o(pin_b_o),
    .pin_oe_o(pin_b_oe_o),
    .latch_o(b_latch),
    .pin_level_o(b_level)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Mux computed at acceptance so data is stable under ack;
  // unmapped words and write-only words return zero
  always @* begin
    rdata_nxt = `RST_RDATA;
    if (accept & ~we_i) begin
      case (word_adr)
        `OFS_PORT_A_PIN_DATA: begin
          rdata_nxt[PA_W-1:0] = a_level; // [R13]
        end
        `OFS_PORT_B_PIN_DATA: begin
          rdata_nxt[PB_W-1:0] = b_level; // [R13] [R11]
        end
        `OFS_PORT_A_FUNC_SEL: begin
          rdata_nxt[PA_W-1:0] = a_fsel_r;
        end
        `OFS_PORT_A_DIRECTION: begin
          rdata_nxt[PA_W-1:0] = a_dir_r;
        end
        `OFS_PORT_B_FUNC_SEL: begin
          rdata_nxt[PB_W-1:0] = b_fsel_r;
        end
        `OFS_PORT_B_DIRECTION: begin
          rdata_nxt[PB_W-1:0] = b_dir_r;
        end
        `OFS_PORT_A_LATCH_VIEW: begin
          rdata_nxt[PA_W-1:0] = a_latch;
        end
        `OFS_PORT_B_LATCH_VIEW: begin
          rdata_nxt[PB_W-1:0] = b_latch;
        end
        // Set, clear and toggle words never echo what was written
        `OFS_PORT_A_LATCH_SET,
        `OFS_PORT_A_LATCH_CLEAR,
        `OFS_PORT_A_LATCH_TOGGLE,
        `OFS_PORT_B_LATCH_SET,
        `OFS_PORT_B_LATCH_CLEAR,
        `OFS_PORT_B_LATCH_TOGGLE: begin
          rdata_nxt = `RST_RDATA; // [R5]
        end
        // Unmapped words read as zero
        default: begin
          rdata_nxt = `RST_RDATA;
        end
      endcase
    end
  end

  // Held through the ack cycle, zero otherwise
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= `RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign dat_o = rdata_r;

endmodule // gpio_latch_set_clear_toggle

// ===== test/gpio_latch_checker.sv
`timescale 1ns/1ps
`include "gpio_latch_regs.vh"

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module gpio_latch_checker #(
  parameter PA_W = 32,
  parameter PB_W = 3
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // Pins
  input wire [PA_W-1:0] pin_a_o,
  input wire [PA_W-1:0] pin_a_oe_o,
  input wire [PB_W-1:0] pin_b_o,
  input wire [PB_W-1:0] pin_b_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Full-word write at its ack edge; narrow lanes are not judged here
  wire wacc = ack_o && we_i && sel_i == 4'hf;
  wire [PB_W-1:0] dat_b = dat_i[PB_W-1:0];
  // Bus handshake and write-only reads
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  ack_delay_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  ack_cause_a: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
  wo_read_a: assert property (ack_o && !we_i && adr_i[7:5] == 3'h0 && adr_i[4:2] >= 3'h2 |-> dat_o == 32'h0)
    else $error("write-only register read nonzero");
  // Latch updates, one cycle after the ack edge
  a_set_a: assert property (wacc && adr_i == `OFS_PORT_A_LATCH_SET
    |=> pin_a_o == ($past(pin_a_o) | $past(dat_i))) else $error("port a set wrong");
  a_clear_a: assert property (wacc && adr_i == `OFS_PORT_A_LATCH_CLEAR
    |=> pin_a_o == ($past(pin_a_o) & ~$past(dat_i))) else $error("port a clear wrong");
  a_toggle_a: assert property (wacc && adr_i == `OFS_PORT_A_LATCH_TOGGLE
    |=> pin_a_o == ($past(pin_a_o) ^ $past(dat_i))) else $error("port a toggle wrong");
  b_set_a: assert property (wacc && adr_i == `OFS_PORT_B_LATCH_SET
    |=> pin_b_o == ($past(pin_b_o) | $past(dat_b))) else $error("port b set wrong");
  b_clear_a: assert property (wacc && adr_i == `OFS_PORT_B_LATCH_CLEAR
    |=> pin_b_o == ($past(pin_b_o) & ~$past(dat_b))) else $error("port b clear wrong");
  b_toggle_a: assert property (wacc && adr_i == `OFS_PORT_B_LATCH_TOGGLE
    |=> pin_b_o == ($past(pin_b_o) ^ $past(dat_b))) else $error("port b toggle wrong");
  // Read data stands only under ack
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  // Nothing moves without a write
  idle_hold_a: assert property (!(ack_o && we_i) |=> $stable(pin_a_o) && $stable(pin_b_o)
    && $stable(pin_a_oe_o) && $stable(pin_b_oe_o)) else $error("pins moved without write");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |=> pin_a_o == 0 && pin_b_o == 0
    && pin_a_oe_o == 0 && pin_b_oe_o == 0 && !ack_o) else $error("reset state wrong");
  // Main scenarios reached
  cover property (wacc && adr_i == `OFS_PORT_A_LATCH_TOGGLE);
  cover property (wacc && adr_i == `OFS_PORT_B_LATCH_CLEAR);
  cover property (ack_o && !we_i && adr_i == `OFS_PORT_A_PIN_DATA);
endmodule // gpio_latch_checker

bind gpio_latch_set_clear_toggle gpio_latch_checker #(.PA_W(PA_W), .PB_W(PB_W)) gpio_latch_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_a_o(pin_a_o), .pin_a_oe_o(pin_a_oe_o),
  .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o));

// ===== test/gpio_latch_set_clear_toggle_bench.sv
`timescale 1ns/1ps

module gpio_latch_set_clear_toggle_bench;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic we_i = 0;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 0;
  logic [31:0] pin_a_i = 0;
  logic [2:0] pin_b_i = 0;
  wire [31:0] dat_o;
  wire [31:0] pin_a_o;
  wire [31:0] pin_a_oe_o;
  wire [2:0] pin_b_o;
  wire [2:0] pin_b_oe_o;
  wire ack_o;
  // Reference model: latches and pin configuration
  logic [31:0] ma = 0, fa = 0, da = 0, d;
  logic [2:0] mb = 0, fb = 0, db = 0;
  int op;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] rd_q[$];
  logic [69:0] pin_q[$];

  // Clock
  always #4 clk_i = ~clk_i;

  gpio_latch_set_clear_toggle gpio_latch_set_clear_toggle_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_a_i(pin_a_i),
    .pin_a_o(pin_a_o), .pin_a_oe_o(pin_a_oe_o), .pin_b_i(pin_b_i), .pin_b_o(pin_b_o),
    .pin_b_oe_o(pin_b_oe_o));

  // ----------------------------------------------------------------
  // Comparison and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [69:0] e, input logic [69:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] e);
    check("read data", {38'h0, e}, {38'h0, dat_o});
  endtask
  task automatic cmp_pins(input logic [69:0] e);
    check("pins", e, {pin_a_o, pin_b_o, pin_a_oe_o, pin_b_oe_o});
  endtask
  // Drive enable is GPIO function and output direction together
  function automatic logic [69:0] exp_pins();
    return {ma, mb, ~fa & da, ~fb & db};
  endfunction
  // Classic cycle: hold the request until ack is seen at an edge
  task automatic bus(input logic [7:0] a, input logic [31:0] v, input logic w);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= v;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    pin_q.push_back(exp_pins());
    bus(a, v, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(a, 32'h0, 1'b0);
  endtask
  task automatic do_reset;
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    {ma, mb, fa, da, fb, db} = 0;
    @(negedge clk_i);
    cmp_pins(exp_pins());
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Monitor: read data in the ack cycle, pins after the write lands
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i) begin
      @(negedge clk_i);
      cmp_pins(pin_q.pop_front());
    end else if (ack_o === 1'b1) cmp_rd(rd_q.pop_front());
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h6bd1));
    do_reset;
    da = $urandom;
    wr(8'h24, da);
    fa = $urandom;
    wr(8'h20, fa);
    db = 3'h3;
    wr(8'h2c, {29'h0, db});
    fb = 3'h2;
    wr(8'h28, {29'h0, fb});
    rd(8'h20, fa);
    rd(8'h24, da);
    rd(8'h28, {29'h0, fb});
    rd(8'h2c, {29'h0, db});
    // All-ones, all-zeros, then random words on every operation
    for (int i = 0; i < 36; i++) begin
      op = i % 6;
      d = (i < 6) ? 32'hffffffff : (i < 12) ? 32'h0 : $urandom;
      case (op)
        0: ma = ma | d;
        1: ma = ma & ~d;
        2: ma = ma ^ d;
        3: mb = mb | d[2:0];
        4: mb = mb & ~d[2:0];
        default: mb = mb ^ d[2:0];
      endcase
      wr(8'h08 + 8'(op * 4), d);
      rd(8'h08 + 8'(op * 4), 32'h0);
    end
    // Partial lanes: unselected bytes carry no ones
    sel_i <= 4'h5;
    d = $urandom;
    ma = ma | (d & 32'h00ff00ff);
    wr(8'h08, d);
    d = $urandom;
    ma = (ma & 32'hff00ff00) | (d & 32'h00ff00ff);
    wr(8'h00, d);
    sel_i <= 4'hf;
    rd(8'h30, ma);
    rd(8'h34, {29'h0, mb});
    // Data register reads the pin, not the latch
    pin_a_i <= $urandom;
    pin_b_i <= 3'($urandom);
    repeat (3) @(posedge clk_i);
    rd(8'h00, pin_a_i);
    rd(8'h04, {29'h0, pin_b_i});
    ma = $urandom;
    wr(8'h00, ma);
    wr(8'h3c, $urandom);
    rd(8'h3c, 32'h0);
    do_reset;
    ma = 32'h80000001;
    wr(8'h10, ma);
    repeat (4) @(posedge clk_i);
    report_and_stop;
  end
endmodule // gpio_latch_set_clear_toggle_bench
